//--- verilog/lsoc_pkg.sv
// Constants and types shared by the laser status and output control block
package lsoc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 2;
  localparam int FUNC_W = 3;
  localparam int REG_W = 16;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_SET_PIN_FUNC,
    OP_QRY_PIN_FUNC,
    OP_QRY_PIN_LEVEL,
    OP_SET_DISPLAY,
    OP_QRY_DISPLAY,
    OP_SET_COND_MASK,
    OP_QRY_COND_MASK,
    OP_SET_EVT_MASK,
    OP_QRY_EVT_MASK,
    OP_SET_SHDN,
    OP_QRY_SHDN,
    OP_QRY_EVENTS
  } lsoc_op_t;

  // ----------------------------------------------------------------
  // Output pin function codes
  // ----------------------------------------------------------------
  localparam logic [FUNC_W-1:0] FUNC_FORCE_LOW = 3'h0;
  localparam logic [FUNC_W-1:0] FUNC_FORCE_HIGH = 3'h1;
  localparam logic [FUNC_W-1:0] FUNC_OUTPUT_ON = 3'h2;
  localparam logic [FUNC_W-1:0] FUNC_STABLE = 3'h3;
  localparam logic [FUNC_W-1:0] FUNC_TEMP_LIMIT = 3'h4;
  localparam logic [FUNC_W-1:0] FUNC_CURR_LIMIT = 3'h5;
  localparam logic [FUNC_W-1:0] FUNC_REMOTE = 3'h6;
  localparam logic [PORT_W-1:0] RELAY_PORT = 2'h0;

  // ----------------------------------------------------------------
  // Reset values and fixed masks
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] SHDN_RESET = 16'hfd9e;
  localparam logic [REG_W-1:0] SHDN_FORCED = 16'h9192;
  localparam logic [REG_W-1:0] COND_MASK_RESET = 16'h0000;
  localparam logic [REG_W-1:0] EVT_MASK_RESET = 16'h0000;
  localparam logic [REG_W-1:0] EVT_EDGE_MASK = 16'h61bf;
  localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;
  localparam logic DISPLAY_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int EVT_OUT_OF_TOL = 9;
  localparam int EVT_OUTPUT = 10;
  localparam int EVT_NEW_DATA = 11;
  localparam int EVT_TEC = 12;
  localparam int FLT_TEC_OFF = 10;
  localparam int FLT_TEC_LIMIT = 11;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    lsoc_op_t op;
    logic [PORT_W-1:0] port;
    logic [FUNC_W-1:0] func;
    logic invert;
    logic [REG_W-1:0] data;
  } lsoc_cmd_t;

  typedef struct packed {
    logic output_on;
    logic stable;
    logic temp_limit;
    logic current_limit;
    logic remote_mode;
    logic out_of_tol;
    logic new_data;
  } lsoc_state_t;

  typedef struct packed {
    logic err;
    logic [REG_W-1:0] data;
  } lsoc_rsp_t;

endpackage : lsoc_pkg

//--- verilog/lsoc_top.sv
// Laser channel status and output control logic
`timescale 1ns/10ps
// Operation
// - Port function codes select forced or status levels
// - Invert chooses active-high or active-low pin
// - Codes 0 and 1 ignore invert
// - Relay port 0 runs non-inverted only
// - Port query returns stored function and invert
// - Display flag 0 disables display and panel
// - Only remote write of 1 releases lockout
// - Display query returns flag as written
// - Condition mask gates conditions into summary
// - Condition mask query returns stored value
// - Event mask gates events into summary
// - Event mask query returns stored value
// - Enabled faults turn laser output off
// - Shutdown mask bits follow fixed fault map
// - Bits 1,4,7,8,12,15 always act set
// - Shutdown mask resets to 64926
// - Shutdown mask query returns current value
// - Event bits follow fixed event map
// - Event bit 12 on TEC limit or off
// - Event read returns contents then clears
module lsoc_top (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire lsoc_pkg::lsoc_cmd_t cmd_i,
  input wire logic [lsoc_pkg::REG_W-1:0] fault_i,
  input wire logic [lsoc_pkg::REG_W-1:0] cond_i,
  input wire lsoc_pkg::lsoc_state_t state_i,
  input wire logic panel_key_i,
  output logic rsp_valid_o,
  output lsoc_pkg::lsoc_rsp_t rsp_o,
  output logic [lsoc_pkg::NUM_PORTS-1:0] pin_o,
  output logic shutdown_o,
  output logic summary_o,
  output logic display_enable_o,
  output logic panel_key_o
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic port_ok;
  logic func_ok;
  logic do_set_pin;
  logic do_set_disp;
  logic do_set_cond;
  logic do_set_evt;
  logic do_set_shdn;
  logic do_read_evt;

  always_comb begin
    port_ok = (int'(cmd_i.port) < lsoc_pkg::NUM_PORTS);
    func_ok = (cmd_i.func <= lsoc_pkg::FUNC_REMOTE);
    do_set_pin = cmd_valid_i && (cmd_i.op == lsoc_pkg::OP_SET_PIN_FUNC) && port_ok && func_ok;
    do_set_disp = cmd_valid_i && (cmd_i.op == lsoc_pkg::OP_SET_DISPLAY);
    do_set_cond = cmd_valid_i && (cmd_i.op == lsoc_pkg::OP_SET_COND_MASK);
    do_set_evt = cmd_valid_i && (cmd_i.op == lsoc_pkg::OP_SET_EVT_MASK);
    do_set_shdn = cmd_valid_i && (cmd_i.op == lsoc_pkg::OP_SET_SHDN);
    do_read_evt = cmd_valid_i && (cmd_i.op == lsoc_pkg::OP_QRY_EVENTS);
  end

  // ----------------------------------------------------------------
  // Output pin configuration and drive
  // ----------------------------------------------------------------
  logic [lsoc_pkg::FUNC_W-1:0] func_r [lsoc_pkg::NUM_PORTS];
  logic [lsoc_pkg::FUNC_W-1:0] func_nxt [lsoc_pkg::NUM_PORTS];
  logic [lsoc_pkg::NUM_PORTS-1:0] inv_r;
  logic [lsoc_pkg::NUM_PORTS-1:0] inv_nxt;
  logic [lsoc_pkg::NUM_PORTS-1:0] pin_r;
  logic [lsoc_pkg::NUM_PORTS-1:0] pin_nxt;

  genvar gp;
  generate
    for (gp = 0; gp < lsoc_pkg::NUM_PORTS; gp++) begin : g_port
      logic active;
      always_comb begin
        func_nxt[gp] = func_r[gp];
        inv_nxt[gp] = inv_r[gp];
        if (do_set_pin && (int'(cmd_i.port) == gp)) begin
          func_nxt[gp] = cmd_i.func;
          if (cmd_i.port == lsoc_pkg::RELAY_PORT) begin
            inv_nxt[gp] = 1'b0;
          end else begin
            inv_nxt[gp] = cmd_i.invert;
          end
        end
        active = 1'b0;
        unique case (func_r[gp])
          lsoc_pkg::FUNC_OUTPUT_ON: active = state_i.output_on;
          lsoc_pkg::FUNC_STABLE: active = state_i.stable;
          lsoc_pkg::FUNC_TEMP_LIMIT: active = state_i.temp_limit;
          lsoc_pkg::FUNC_CURR_LIMIT: active = state_i.current_limit;
          lsoc_pkg::FUNC_REMOTE: active = state_i.remote_mode;
          default: active = 1'b0;
        endcase
        unique case (func_r[gp])
          lsoc_pkg::FUNC_FORCE_LOW: begin
            pin_nxt[gp] = 1'b0;
          end
          lsoc_pkg::FUNC_FORCE_HIGH: begin
            pin_nxt[gp] = 1'b1;
          end
          default: begin
            pin_nxt[gp] = active ^ inv_r[gp];
          end
        endcase
      end

      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          func_r[gp] <= lsoc_pkg::FUNC_FORCE_LOW;
          inv_r[gp] <= 1'b0;
          pin_r[gp] <= 1'b0;
        end else begin
          func_r[gp] <= func_nxt[gp];
          inv_r[gp] <= inv_nxt[gp];
          pin_r[gp] <= pin_nxt[gp];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Display and front panel lockout
  // ----------------------------------------------------------------
  logic disp_r;
  logic disp_nxt;
  logic panel_key_r;
  logic panel_key_nxt;

  always_comb begin
    disp_nxt = disp_r;
    if (do_set_disp) begin
      disp_nxt = cmd_i.data[0];
    end
    panel_key_nxt = 1'b0;
    if (disp_r) begin
      panel_key_nxt = panel_key_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      disp_r <= lsoc_pkg::DISPLAY_RESET;
      panel_key_r <= 1'b0;
    end else begin
      disp_r <= disp_nxt;
      panel_key_r <= panel_key_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Masks
  // ----------------------------------------------------------------
  logic [lsoc_pkg::REG_W-1:0] cond_mask_r;
  logic [lsoc_pkg::REG_W-1:0] cond_mask_nxt;
  logic [lsoc_pkg::REG_W-1:0] evt_mask_r;
  logic [lsoc_pkg::REG_W-1:0] evt_mask_nxt;
  logic [lsoc_pkg::REG_W-1:0] shdn_r;
  logic [lsoc_pkg::REG_W-1:0] shdn_nxt;

  always_comb begin
    cond_mask_nxt = cond_mask_r;
    evt_mask_nxt = evt_mask_r;
    shdn_nxt = shdn_r;
    if (do_set_cond) begin
      cond_mask_nxt = cmd_i.data;
    end
    if (do_set_evt) begin
      evt_mask_nxt = cmd_i.data;
    end
    if (do_set_shdn) begin
      shdn_nxt = cmd_i.data | lsoc_pkg::SHDN_FORCED;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cond_mask_r <= lsoc_pkg::COND_MASK_RESET;
      evt_mask_r <= lsoc_pkg::EVT_MASK_RESET;
      shdn_r <= lsoc_pkg::SHDN_RESET;
    end else begin
      cond_mask_r <= cond_mask_nxt;
      evt_mask_r <= evt_mask_nxt;
      shdn_r <= shdn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Event register
  // ----------------------------------------------------------------
  logic [lsoc_pkg::REG_W-1:0] events_r;
  logic [lsoc_pkg::REG_W-1:0] events_nxt;
  logic [lsoc_pkg::REG_W-1:0] fault_prev_r;
  logic oot_prev_r;
  logic out_prev_r;
  logic tec_prev_r;
  logic [lsoc_pkg::REG_W-1:0] evt_set;
  logic tec_err;

  always_comb begin
    tec_err = fault_i[lsoc_pkg::FLT_TEC_OFF] | fault_i[lsoc_pkg::FLT_TEC_LIMIT];
    evt_set = fault_i & ~fault_prev_r & lsoc_pkg::EVT_EDGE_MASK;
    evt_set[lsoc_pkg::EVT_OUT_OF_TOL] = state_i.out_of_tol ^ oot_prev_r;
    evt_set[lsoc_pkg::EVT_OUTPUT] = state_i.output_on ^ out_prev_r;
    evt_set[lsoc_pkg::EVT_NEW_DATA] = state_i.new_data;
    evt_set[lsoc_pkg::EVT_TEC] = tec_err & ~tec_prev_r;
    if (do_read_evt) begin
      events_nxt = evt_set;
    end else begin
      events_nxt = events_r | evt_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      events_r <= lsoc_pkg::REG_ZERO;
      fault_prev_r <= lsoc_pkg::REG_ZERO;
      oot_prev_r <= 1'b0;
      out_prev_r <= 1'b0;
      tec_prev_r <= 1'b0;
    end else begin
      events_r <= events_nxt;
      fault_prev_r <= fault_i;
      oot_prev_r <= state_i.out_of_tol;
      out_prev_r <= state_i.output_on;
      tec_prev_r <= tec_err;
    end
  end

  // ----------------------------------------------------------------
  // Shutdown and status summary
  // ----------------------------------------------------------------
  logic shutdown_r;
  logic shutdown_nxt;
  logic summary_r;
  logic summary_nxt;
  logic [lsoc_pkg::REG_W-1:0] shdn_hits;
  logic cond_hit;
  logic evt_hit;

  always_comb begin
    shdn_hits = fault_i & (shdn_r | lsoc_pkg::SHDN_FORCED);
    cond_hit = |(cond_i & cond_mask_r);
    evt_hit = |(events_r & evt_mask_r);
    shutdown_nxt = |shdn_hits;
    summary_nxt = cond_hit | evt_hit;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shutdown_r <= 1'b0;
      summary_r <= 1'b0;
    end else begin
      shutdown_r <= shutdown_nxt;
      summary_r <= summary_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Query responses
  // ----------------------------------------------------------------
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  lsoc_pkg::lsoc_rsp_t rsp_r;
  lsoc_pkg::lsoc_rsp_t rsp_nxt;
  logic [lsoc_pkg::FUNC_W-1:0] sel_func;
  logic sel_inv;
  logic sel_pin;

  always_comb begin
    sel_func = func_r[cmd_i.port];
    sel_inv = inv_r[cmd_i.port];
    sel_pin = pin_r[cmd_i.port];
    rsp_valid_nxt = cmd_valid_i && (cmd_i.op != lsoc_pkg::OP_NONE);
    rsp_nxt.err = 1'b0;
    rsp_nxt.data = lsoc_pkg::REG_ZERO;
    unique case (cmd_i.op)
      lsoc_pkg::OP_SET_PIN_FUNC: begin
        rsp_nxt.err = !(port_ok && func_ok);
      end
      lsoc_pkg::OP_QRY_PIN_FUNC: begin
        rsp_nxt.err = !port_ok;
        rsp_nxt.data = {12'h000, sel_inv, sel_func};
      end
      lsoc_pkg::OP_QRY_PIN_LEVEL: begin
        rsp_nxt.err = !port_ok;
        rsp_nxt.data = {15'h0000, sel_pin};
      end
      lsoc_pkg::OP_QRY_DISPLAY: begin
        rsp_nxt.data = {15'h0000, disp_r};
      end
      lsoc_pkg::OP_QRY_COND_MASK: begin
        rsp_nxt.data = cond_mask_r;
      end
      lsoc_pkg::OP_QRY_EVT_MASK: begin
        rsp_nxt.data = evt_mask_r;
      end
      lsoc_pkg::OP_QRY_SHDN: begin
        rsp_nxt.data = shdn_r;
      end
      lsoc_pkg::OP_QRY_EVENTS: begin
        rsp_nxt.data = events_r;
      end
      lsoc_pkg::OP_SET_DISPLAY,
      lsoc_pkg::OP_SET_COND_MASK,
      lsoc_pkg::OP_SET_EVT_MASK,
      lsoc_pkg::OP_SET_SHDN,
      lsoc_pkg::OP_NONE: begin
        rsp_nxt.err = 1'b0;
      end
      default: begin
        rsp_nxt.err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_o = rsp_r;
  assign pin_o = pin_r;
  assign shutdown_o = shutdown_r;
  assign summary_o = summary_r;
  assign display_enable_o = disp_r;
  assign panel_key_o = panel_key_r;

endmodule : lsoc_top

//--- verif/lsoc_top_monitor.sv
// Concurrent checks on the ports of the laser status and output control block
`timescale 1ns/10ps
module lsoc_top_monitor (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire lsoc_pkg::lsoc_cmd_t cmd_i,
  input wire logic [lsoc_pkg::REG_W-1:0] fault_i,
  input wire logic [lsoc_pkg::REG_W-1:0] cond_i,
  input wire lsoc_pkg::lsoc_state_t state_i,
  input wire logic panel_key_i,
  input wire logic rsp_valid_o,
  input wire lsoc_pkg::lsoc_rsp_t rsp_o,
  input wire logic [lsoc_pkg::NUM_PORTS-1:0] pin_o,
  input wire logic shutdown_o,
  input wire logic summary_o,
  input wire logic display_enable_o,
  input wire logic panel_key_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic is_disp;
  logic is_shdn;
  assign is_disp = cmd_valid_i && (cmd_i.op == lsoc_pkg::OP_SET_DISPLAY);
  assign is_shdn = cmd_valid_i && (cmd_i.op == lsoc_pkg::OP_SET_SHDN);
  a_rsp_timing: assert property (cmd_valid_i && cmd_i.op != lsoc_pkg::OP_NONE |=> rsp_valid_o)
    else $error("command not answered");
  a_shdn_forced: assert property ((fault_i & lsoc_pkg::SHDN_FORCED) != lsoc_pkg::REG_ZERO |=> shutdown_o)
    else $error("forced fault did not shut down");
  a_no_fault_run: assert property (fault_i == lsoc_pkg::REG_ZERO |=> !shutdown_o)
    else $error("shutdown without fault");
  a_panel_locked: assert property (!display_enable_o [*3] |-> !panel_key_o)
    else $error("panel input passed while locked");
  a_lock_holds: assert property (!display_enable_o && !is_disp |=> !display_enable_o)
    else $error("lockout released locally");
  a_disp_write: assert property (is_disp |=> display_enable_o == $past(cmd_i.data[0]))
    else $error("display flag not written");
  a_disp_query: assert property (is_disp ##1 cmd_valid_i && cmd_i.op == lsoc_pkg::OP_QRY_DISPLAY |=>
    rsp_o.data[0] == $past(cmd_i.data[0], 2))
    else $error("display query wrong");
  a_shdn_query: assert property (is_shdn ##1 cmd_valid_i && cmd_i.op == lsoc_pkg::OP_QRY_SHDN |=>
    rsp_o.data == ($past(cmd_i.data, 2) | lsoc_pkg::SHDN_FORCED))
    else $error("shutdown mask query wrong");
endmodule : lsoc_top_monitor

//--- verif/lsoc_host.sv
// Host model that issues commands and captures answers
`timescale 1ns/10ps
module lsoc_host (
  input wire logic clk_i,
  input wire logic rsp_valid_i,
  input wire lsoc_pkg::lsoc_rsp_t rsp_i,
  output logic cmd_valid_o,
  output lsoc_pkg::lsoc_cmd_t cmd_o
);
  lsoc_pkg::lsoc_rsp_t r;
  logic rv;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  task automatic send(input lsoc_pkg::lsoc_op_t op, input logic [15:0] d, input logic [1:0] p,
    input logic [2:0] f, input logic v);
    cmd_o.op = op;
    cmd_o.port = p;
    cmd_o.func = f;
    cmd_o.invert = (p == lsoc_pkg::RELAY_PORT) ? 1'b0 : v;
    cmd_o.data = d;
    cmd_valid_o = 1'b1;
    @(posedge clk_i);
    #1;
    rv = rsp_valid_i;
    r = rsp_i;
  endtask : send
  task automatic stop();
    cmd_valid_o = 1'b0;
    cmd_o = ~cmd_o;
  endtask : stop
endmodule : lsoc_host

//--- verif/lsoc_top_tb.sv
// Self-checking testbench for the laser status and output control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module laser_status_output_control_tb;
  logic core_clk_i = 1'b0;
  logic resetn_i;
  logic cmd_valid_i;
  lsoc_pkg::lsoc_cmd_t cmd_i;
  logic [15:0] fault_i;
  logic [15:0] cond_i;
  lsoc_pkg::lsoc_state_t state_i;
  logic panel_key_i;
  logic rsp_valid_o;
  lsoc_pkg::lsoc_rsp_t rsp_o;
  logic [3:0] pin_o;
  logic shutdown_o;
  logic summary_o;
  logic display_enable_o;
  logic panel_key_o;
  int checked = 0;
  int mismatches = 0;
  always #50 core_clk_i = ~core_clk_i;
  lsoc_top dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .fault_i(fault_i), .cond_i(cond_i), .state_i(state_i), .panel_key_i(panel_key_i),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .pin_o(pin_o), .shutdown_o(shutdown_o),
    .summary_o(summary_o), .display_enable_o(display_enable_o), .panel_key_o(panel_key_o));
  lsoc_host host (.clk_i(core_clk_i), .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o), .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc
  task automatic q(input lsoc_pkg::lsoc_op_t op, input logic [15:0] d = '0, input logic [1:0] p = '0,
    input logic [2:0] f = '0, input logic v = '0);
    host.send(op, d, p, f, v);
    host.stop();
    cyc(1);
  endtask : q
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_reset();
    `CHK("disp", 1'b1, display_enable_o)
    `CHK("pins", 4'h0, pin_o)
    q(lsoc_pkg::OP_QRY_SHDN);
    `CHK("shdn_rst", 16'hfd9e, host.r.data)
  endtask : t_reset
  task automatic t_pins();
    for (int f = 0; f < 7; f++) begin
      for (int v = 0; v < 2; v++) begin
        for (int a = 0; a < 2; a++) begin
          state_i = a[0] ? lsoc_pkg::lsoc_state_t'(7'h1 << (8 - f)) : '0;
          q(lsoc_pkg::OP_SET_PIN_FUNC, '0, 2'h1, 3'(f), v[0]);
          cyc(2);
          `CHK("pin", (f < 2) ? f[0] : (a[0] ^ v[0]), pin_o[1])
          q(lsoc_pkg::OP_QRY_PIN_FUNC, '0, 2'h1);
          `CHK("mode", {12'h0, v[0], 3'(f)}, host.r.data)
        end
      end
    end
    state_i = '0;
    state_i.output_on = 1'b1;
    q(lsoc_pkg::OP_SET_PIN_FUNC, '0, 2'h0, lsoc_pkg::FUNC_OUTPUT_ON, 1'b1);
    cyc(2);
    `CHK("relay", 1'b1, pin_o[0])
    q(lsoc_pkg::OP_QRY_PIN_FUNC, '0, 2'h0);
    `CHK("relay_mode", 16'h0002, host.r.data)
    q(lsoc_pkg::OP_QRY_PIN_LEVEL, '0, 2'h0);
    `CHK("relay_lvl", 16'h0001, host.r.data)
    q(lsoc_pkg::OP_SET_PIN_FUNC, '0, 2'h0, 3'h7, 1'b0);
    `CHK("bad_func", 1'b1, host.r.err)
    `CHK("rsp_seen", 1'b1, host.rv)
    q(lsoc_pkg::OP_QRY_PIN_FUNC, '0, 2'h0);
    `CHK("func_kept", 16'h0002, host.r.data)
    state_i = '0;
  endtask : t_pins
  task automatic t_display();
    panel_key_i = 1'b1;
    q(lsoc_pkg::OP_SET_DISPLAY, 16'h0000);
    `CHK("disp_off", 1'b0, display_enable_o)
    cyc(3);
    `CHK("key_locked", 1'b0, panel_key_o)
    `CHK("still_off", 1'b0, display_enable_o)
    q(lsoc_pkg::OP_QRY_DISPLAY);
    `CHK("disp_q0", 1'b0, host.r.data[0])
    host.send(lsoc_pkg::OP_SET_DISPLAY, 16'h0001, '0, '0, '0);
    host.send(lsoc_pkg::OP_QRY_DISPLAY, '0, '0, '0, '0);
    host.stop();
    cyc(2);
    `CHK("disp_q1", 1'b1, host.r.data[0])
    `CHK("key_free", 1'b1, panel_key_o)
    panel_key_i = 1'b0;
  endtask : t_display
  task automatic t_shdn();
    host.send(lsoc_pkg::OP_SET_SHDN, 16'h0000, '0, '0, '0);
    host.send(lsoc_pkg::OP_QRY_SHDN, '0, '0, '0, '0);
    host.stop();
    cyc(1);
    `CHK("mask_q", 16'h9192, host.r.data)
    for (int b = 0; b < 16; b++) begin
      fault_i = 16'h0001 << b;
      cyc(2);
      `CHK("shdn_bit", lsoc_pkg::SHDN_FORCED[b], shutdown_o)
    end
    fault_i = 16'h0001;
    q(lsoc_pkg::OP_SET_SHDN, 16'h0001);
    cyc(1);
    `CHK("shdn_en", 1'b1, shutdown_o)
    fault_i = '0;
    cyc(2);
  endtask : t_shdn
  task automatic t_events();
    q(lsoc_pkg::OP_QRY_EVENTS);
    fault_i = 16'h8041;
    cyc(1);
    fault_i = '0;
    cyc(2);
    q(lsoc_pkg::OP_QRY_EVENTS);
    `CHK("evt_latch", 16'h0001, host.r.data)
    q(lsoc_pkg::OP_QRY_EVENTS);
    `CHK("evt_clr", 16'h0000, host.r.data)
    fault_i = 16'h0400;
    cyc(2);
    fault_i = '0;
    q(lsoc_pkg::OP_QRY_EVENTS);
    `CHK("evt_tec", 16'h1000, host.r.data)
    state_i.new_data = 1'b1;
    cyc(1);
    state_i = '0;
    q(lsoc_pkg::OP_QRY_EVENTS);
    `CHK("evt_data", 16'h0800, host.r.data)
  endtask : t_events
  task automatic t_summary();
    cond_i = 16'h0004;
    cyc(2);
    `CHK("sum_mask0", 1'b0, summary_o)
    q(lsoc_pkg::OP_SET_COND_MASK, 16'h0004);
    cyc(1);
    `CHK("sum_cond", 1'b1, summary_o)
    q(lsoc_pkg::OP_QRY_COND_MASK);
    `CHK("cmask_q", 16'h0004, host.r.data)
    cond_i = '0;
    q(lsoc_pkg::OP_SET_EVT_MASK, 16'h0800);
    q(lsoc_pkg::OP_QRY_EVT_MASK);
    `CHK("emask_q", 16'h0800, host.r.data)
    `CHK("sum_idle", 1'b0, summary_o)
    state_i.new_data = 1'b1;
    cyc(1);
    state_i = '0;
    cyc(2);
    `CHK("sum_evt", 1'b1, summary_o)
    q(lsoc_pkg::OP_QRY_EVENTS);
    cyc(1);
    `CHK("sum_clr", 1'b0, summary_o)
  endtask : t_summary
  initial begin
    resetn_i = 1'b0;
    fault_i = '0;
    cond_i = '0;
    state_i = '0;
    panel_key_i = 1'b0;
    cyc(16);
    resetn_i = 1'b1;
    cyc(1);
    t_reset();
    t_pins();
    t_display();
    t_shdn();
    t_events();
    t_summary();
    tally_and_finish();
  end
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule : laser_status_output_control_tb
bind lsoc_top lsoc_top_monitor mon (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i), .fault_i(fault_i), .cond_i(cond_i), .state_i(state_i), .panel_key_i(panel_key_i),
  .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .pin_o(pin_o), .shutdown_o(shutdown_o), .summary_o(summary_o),
  .display_enable_o(display_enable_o), .panel_key_o(panel_key_o));
